// *** dmls_pkg.sv ***
// Package for the data move load/store unit: opcodes, sizes, constants and carriers.
package dmls_pkg;

  // Opcode fields.
  localparam logic [3:0] OP_ZERO = 4'h0;
  localparam logic [3:0] OP_STORE = 4'h2;
  localparam logic [3:0] OP_LOAD = 4'h6;
  localparam logic [3:0] OP_PCW = 4'h9;
  localparam logic [3:0] OP_PCL = 4'hD;
  localparam logic [3:0] OP_IMM = 4'hE;

  // Low nibble codes within groups 2, 6 and 0.
  localparam logic [1:0] LO_PLAIN = 2'h0;
  localparam logic [1:0] LO_PREPOST = 2'h1;
  localparam logic [3:0] LO_MOVE = 4'h3;
  localparam logic [1:0] LO_IDX_ST = 2'h1;
  localparam logic [1:0] LO_IDX_LD = 2'h3;
  localparam logic [1:0] SZ_BAD = 2'h3;

  // Access sizes.
  typedef enum logic [1:0] {
    DMLS_SZ_BYTE = 2'h0,
    DMLS_SZ_WORD = 2'h1,
    DMLS_SZ_LONG = 2'h2
  } dmls_size_t;

  // Fixed offsets and strides.
  localparam logic [31:0] PC_OFFSET = 32'h0000_0004;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] LONG_ALIGN = 32'hFFFF_FFFC;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [3:0] INDEX_REG = 4'h0;

  // Memory request carrier.
  typedef struct packed {
    logic        valid;
    logic        write;
    dmls_size_t  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmls_mem_req_t;

  // Register file write carrier.
  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } dmls_reg_wr_t;

endpackage

// *** dmls_unit.sv ***
// Decode and execute logic for data-transfer instructions of a 32-bit core.
// Behaviour
// - A register copy writes the whole source register into the destination without memory access.
// - A register-indirect store writes the low byte, word or longword of the source to the destination address.
// - Every byte or word load is sign-extended to 32 bits, and longword loads are written unchanged.
// - A pre-decrement store lowers the destination by 1, 2 or 4 and stores at the lowered address.
// - A post-increment load reads at the source address and then raises the source by 1, 2 or 4, unless source and destination are the same register.
// - Indexed loads and stores address memory at index register zero plus the base register.
// - The immediate load sign-extends the 8-bit field and writes it to the destination.
// - The PC-relative word load reads at PC plus 4 plus twice the displacement and sign-extends.
// - The PC-relative longword load reads at aligned PC plus 4 plus four times the displacement.
// - PC-relative addresses use the address of the load instruction itself plus 4.
// - Only the longword PC-relative load clears the two low bits of the PC first.
// - A PC-relative load in a delay slot raises the illegal slot exception instead of loading.
`timescale 1ns/1ps
`default_nettype none

module dmls_unit (
  input  wire logic                   clk,         // Core clock, 100 MHz.
  input  wire logic                   sys_rst,     // Synchronous reset, active high.
  input  wire logic                   issue,       // Instruction valid this cycle.
  input  wire logic [15:0]            instr,       // Instruction word.
  input  wire logic [31:0]            pc,          // Address of this instruction.
  input  wire logic                   in_slot,     // Instruction sits in a delay slot.
  input  wire logic [31:0]            src_val,     // Value of the source register field.
  input  wire logic [31:0]            dst_val,     // Value of the destination register field.
  input  wire logic [31:0]            idx0_val,    // Value of index register zero.
  input  wire logic [31:0]            mem_rdata,   // Load data, right-aligned, next cycle.
  output logic [3:0]                  src_sel_q,   // Registered mirror of source field.
  output dmls_pkg::dmls_mem_req_t     mem_req_q,   // Memory request, one cycle.
  output dmls_pkg::dmls_reg_wr_t      wr_a_q,      // Primary register write.
  output dmls_pkg::dmls_reg_wr_t      wr_b_q,      // Address update write.
  output logic [31:0]                 pc_next_q,   // Next program counter.
  output logic                        pc_wr_q,     // Program counter update strobe.
  output logic                        slot_exc_q,  // Illegal slot exception pulse.
  output logic                        bad_op_q     // Instruction not handled here.
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode.
  logic [3:0]  op;
  logic [3:0]  rn;
  logic [3:0]  rm;
  logic [3:0]  lo;
  logic [7:0]  imm8;
  logic [31:0] step;
  logic [31:0] pcw_addr;
  logic [31:0] pcl_addr;
  dmls_pkg::dmls_size_t sz;

  assign op   = instr[15:12];
  assign rn   = instr[11:8];
  assign rm   = instr[7:4];
  assign lo   = instr[3:0];
  assign imm8 = instr[7:0];
  assign sz   = dmls_pkg::dmls_size_t'(lo[1:0]);

  // Address stride from the size field.
  always_comb begin
    case (sz)
      dmls_pkg::DMLS_SZ_BYTE: step = dmls_pkg::STEP_BYTE;
      dmls_pkg::DMLS_SZ_WORD: step = dmls_pkg::STEP_WORD;
      default:                step = dmls_pkg::STEP_LONG;
    endcase
  end

  // PC-relative addresses use the instruction's own address plus the offset.
  assign pcw_addr = pc + dmls_pkg::PC_OFFSET + {23'h0, imm8, 1'b0};
  assign pcl_addr = (pc & dmls_pkg::LONG_ALIGN) + dmls_pkg::PC_OFFSET
                    + {22'h0, imm8, 2'b00};

  //////////////////////////////////////////////////////////////////////////////
  // Execute: build requests and writes.
  dmls_pkg::dmls_mem_req_t req_d;
  dmls_pkg::dmls_reg_wr_t  wa_d;
  dmls_pkg::dmls_reg_wr_t  wb_d;
  logic                    load_d;
  logic                    exc_d;
  logic                    bad_d;

  // One decode per cycle; loads register the destination and finish next cycle.
  always_comb begin
    req_d  = '0;
    wa_d   = '0;
    wb_d   = '0;
    load_d = 1'b0;
    exc_d  = 1'b0;
    bad_d  = 1'b0;
    req_d.size = sz;
    if (issue) begin
      case (op)
        dmls_pkg::OP_STORE: begin
          req_d.wdata = src_val;
          if (sz == dmls_pkg::SZ_BAD) begin
            bad_d = 1'b1;
          end else if (lo[3:2] == dmls_pkg::LO_PLAIN) begin
            req_d.valid = 1'b1;
            req_d.write = 1'b1;
            req_d.addr  = dst_val;
          end else if (lo[3:2] == dmls_pkg::LO_PREPOST) begin
            req_d.valid = 1'b1;
            req_d.write = 1'b1;
            req_d.addr  = dst_val - step;
            wb_d = '{en: 1'b1, idx: rn, data: dst_val - step};
          end else begin
            bad_d = 1'b1;
          end
        end
        dmls_pkg::OP_LOAD: begin
          if (lo == dmls_pkg::LO_MOVE) begin
            wa_d = '{en: 1'b1, idx: rn, data: src_val};
          end else if (sz == dmls_pkg::SZ_BAD) begin
            bad_d = 1'b1;
          end else if (lo[3:2] == dmls_pkg::LO_PLAIN) begin
            req_d.valid = 1'b1;
            req_d.addr  = src_val;
            load_d      = 1'b1;
          end else if (lo[3:2] == dmls_pkg::LO_PREPOST) begin
            req_d.valid = 1'b1;
            req_d.addr  = src_val;
            load_d      = 1'b1;
            // Same register: the loaded value wins, no increment.
            if (rn != rm) begin
              wb_d = '{en: 1'b1, idx: rm, data: src_val + step};
            end
          end else begin
            bad_d = 1'b1;
          end
        end
        dmls_pkg::OP_ZERO: begin
          if (sz == dmls_pkg::SZ_BAD) begin
            bad_d = 1'b1;
          end else if (lo[3:2] == dmls_pkg::LO_IDX_ST) begin
            req_d.valid = 1'b1;
            req_d.write = 1'b1;
            req_d.addr  = dst_val + idx0_val;
            req_d.wdata = src_val;
          end else if (lo[3:2] == dmls_pkg::LO_IDX_LD) begin
            req_d.valid = 1'b1;
            req_d.addr  = src_val + idx0_val;
            load_d      = 1'b1;
          end else begin
            bad_d = 1'b1;
          end
        end
        dmls_pkg::OP_IMM: begin
          wa_d = '{en: 1'b1, idx: rn, data: {{24{imm8[7]}}, imm8}};
        end
        dmls_pkg::OP_PCW, dmls_pkg::OP_PCL: begin
          if (in_slot) begin
            exc_d = 1'b1;
          end else begin
            req_d.valid = 1'b1;
            req_d.size  = (op == dmls_pkg::OP_PCW) ? dmls_pkg::DMLS_SZ_WORD
                                                    : dmls_pkg::DMLS_SZ_LONG;
            req_d.addr  = (op == dmls_pkg::OP_PCW) ? pcw_addr : pcl_addr;
            load_d      = 1'b1;
          end
        end
        default: bad_d = 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Load return: extend the data and write the destination.
  logic                 ld_pend_q;
  logic [3:0]           ld_idx_q;
  dmls_pkg::dmls_size_t ld_sz_q;
  logic [31:0]          ld_ext;

  always_comb begin
    case (ld_sz_q)
      dmls_pkg::DMLS_SZ_BYTE: ld_ext = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
      dmls_pkg::DMLS_SZ_WORD: ld_ext = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
      default:                ld_ext = mem_rdata;
    endcase
  end

  // Pending load tracking; the data port answers in the same cycle as the registered request.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ld_pend_q <= 1'b0;
      ld_idx_q  <= 4'h0;
      ld_sz_q   <= dmls_pkg::DMLS_SZ_BYTE;
    end else begin
      ld_pend_q <= load_d;
      ld_idx_q  <= rn;
      ld_sz_q   <= req_d.size;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_req_q  <= '0;
      wr_b_q     <= '0;
      slot_exc_q <= 1'b0;
      bad_op_q   <= 1'b0;
      pc_wr_q    <= 1'b0;
      pc_next_q  <= 32'h0000_0000;
      src_sel_q  <= 4'h0;
    end else begin
      mem_req_q  <= req_d;
      wr_b_q     <= wb_d;
      slot_exc_q <= exc_d;
      bad_op_q   <= bad_d;
      pc_wr_q    <= issue & ~exc_d & ~bad_d;
      pc_next_q  <= pc + dmls_pkg::PC_STEP;
      src_sel_q  <= rm;
    end
  end

  // Primary write: the returning load has priority; issue stalls are the core's job.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_a_q <= '0;
    end else if (ld_pend_q) begin
      wr_a_q <= '{en: 1'b1, idx: ld_idx_q, data: ld_ext};
    end else begin
      wr_a_q <= wa_d;
    end
  end

endmodule

`default_nettype wire

// *** dmls_unit_properties.sv ***
// Assertion checker for the data move load/store unit.
`timescale 1ns/1ps
`default_nettype none
module dmls_unit_properties (
  input wire logic                    clk,        // Clock.
  input wire logic                    sys_rst,    // Reset.
  input wire logic                    issue,      // Issue.
  input wire logic [15:0]             instr,      // Opcode.
  input wire logic [31:0]             pc,         // Address.
  input wire logic                    in_slot,    // Slot flag.
  input wire logic [31:0]             src_val,    // Source.
  input wire logic [31:0]             dst_val,    // Target.
  input wire logic [31:0]             mem_rdata,  // Load data.
  input wire dmls_pkg::dmls_mem_req_t mem_req_q,  // Request.
  input wire dmls_pkg::dmls_reg_wr_t  wr_a_q,     // Write.
  input wire dmls_pkg::dmls_reg_wr_t  wr_b_q,     // Update.
  input wire logic [31:0]             pc_next_q,  // Next address.
  input wire logic                    pc_wr_q,    // Strobe.
  input wire logic                    slot_exc_q  // Trap.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////
  // Reference values worked out from the opcode; size code 3 is not a transfer.
  wire logic [3:0]  op  = instr[15:12];
  wire logic        inc = issue && op == 4'h6 && instr[3:2] == 2'h1 && instr[1:0] != 2'h3;
  wire logic        eq  = instr[11:8] == instr[7:4];
  wire logic [31:0] stp = 32'h1 << instr[1:0];
  wire logic [31:0] pcr = (op[2] ? pc & 32'hFFFF_FFFC : pc) + 32'h4
    + (32'(instr[7:0]) << {op[2], !op[2]});
  wire logic [31:0] ldx = mem_req_q.size[1] ? mem_rdata : mem_req_q.size[0]
    ? {{16{mem_rdata[15]}}, mem_rdata[15:0]} : {{24{mem_rdata[7]}}, mem_rdata[7:0]};
  chk_copy_full: assert property (
    issue && op == 4'h6 && instr[3:0] == 4'h3 |=> wr_a_q.en && !mem_req_q.valid
    && wr_a_q.data == $past(src_val)) else $error("copy wrong");
  chk_predec_addr: assert property (
    issue && op == 4'h2 && instr[3:2] == 2'h1 && instr[1:0] != 2'h3
    |=> mem_req_q.addr == $past(dst_val) - $past(stp) && wr_b_q.data == mem_req_q.addr)
    else $error("decrement wrong");
  chk_postinc_step: assert property (
    inc && !eq |=> mem_req_q.addr == $past(src_val) && wr_b_q.en
    && wr_b_q.data == $past(src_val) + $past(stp)) else $error("increment wrong");
  chk_same_reg: assert property (
    inc && eq |=> !wr_b_q.en ##1 wr_a_q.en) else $error("same register wrong");
  chk_load_extend: assert property (
    mem_req_q.valid && !mem_req_q.write |=> wr_a_q.en && wr_a_q.data == $past(ldx))
    else $error("extension wrong");
  chk_imm_step: assert property (
    issue && op == 4'hE |=> pc_wr_q && pc_next_q == $past(pc) + 32'h2
    && wr_a_q.data == $past({{24{instr[7]}}, instr[7:0]})) else $error("immediate wrong");
  chk_pc_rel: assert property (
    issue && !in_slot && op[1:0] == 2'h1 && op[3] |=> mem_req_q.valid
    && mem_req_q.addr == $past(pcr)) else $error("constant address wrong");
  chk_slot_trap: assert property (
    issue && in_slot && op[1:0] == 2'h1 && op[3] |=> slot_exc_q && !mem_req_q.valid
    && !pc_wr_q) else $error("slot trap wrong");
  cov_load: cover property (mem_req_q.valid && !mem_req_q.write);
  cov_store: cover property (mem_req_q.valid && mem_req_q.write);
  cov_slot: cover property (slot_exc_q);
endmodule
bind dmls_unit dmls_unit_properties u_dmls_unit_properties (.clk, .sys_rst, .issue, .instr,
  .pc, .in_slot, .src_val, .dst_val, .mem_rdata, .mem_req_q, .wr_a_q, .wr_b_q, .pc_next_q,
  .pc_wr_q, .slot_exc_q);
`default_nettype wire

// *** dmls_mem_model.sv ***
// Data memory model that answers a load within the request cycle.
`timescale 1ns/1ps
`default_nettype none
module dmls_mem_model (
  input  wire dmls_pkg::dmls_mem_req_t req,   // Request.
  output logic [31:0]                  rdata  // Load data.
);
  // Junk in the upper bits exposes a missing extension; idle shows the inverse.
  wire logic [31:0] pat = req.addr * 32'h9E37_79B1;
  assign rdata = (req.valid && !req.write) ? pat : ~pat;
endmodule
`default_nettype wire

// *** dmls_unit_tb.sv ***
// Self-checking bench for the data move load/store unit.
`timescale 1ns/1ps
`default_nettype none
module dmls_unit_tb;
  logic                    clk, sys_rst, issue, in_slot, pc_wr_q, slot_exc_q, bad_op_q;
  logic [3:0]              src_sel_q;
  logic [15:0]             instr;
  logic [31:0]             pc, src_val, dst_val, idx0_val, mem_rdata, pc_next_q, r;
  dmls_pkg::dmls_mem_req_t mem_req_q;
  dmls_pkg::dmls_reg_wr_t  wr_a_q, wr_b_q;
  int                      mismatches, comparisons;
  logic [15:0]             ops [22] = '{16'h6003, 16'h2000, 16'h2001, 16'h2002, 16'h2004,
    16'h2005, 16'h2006, 16'h6000, 16'h6001, 16'h6002, 16'h6004, 16'h6005, 16'h6006, 16'h0004,
    16'h0005, 16'h0006, 16'h000C, 16'h000D, 16'h000E, 16'hE000, 16'h9000, 16'hD000};
  dmls_unit u_dmls_unit (.clk, .sys_rst, .issue, .instr, .pc, .in_slot, .src_val, .dst_val,
    .idx0_val, .mem_rdata, .src_sel_q, .mem_req_q, .wr_a_q, .wr_b_q, .pc_next_q, .pc_wr_q,
    .slot_exc_q, .bad_op_q);
  dmls_mem_model u_dmls_mem_model (.req(mem_req_q), .rdata(mem_rdata));
  ////////////////////////////////
  // Clock, and operands that change every cycle so a stale one never matches.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    {src_val, dst_val} <= {$urandom, $urandom};
    idx0_val <= $urandom;
    pc <= $urandom & 32'hFFFF_FFFE;
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Issue one instruction and compare the unit with the reference worked out here.
  task automatic run(logic [15:0] op, logic slot);
    logic [31:0] s, d, p, st, ea, eb, wa;
    logic [1:0]  sz;
    logic        mv, wr, ld, be, ae, ex, bo;
    @(posedge clk);
    issue <= 1'b1;
    instr <= op;
    in_slot <= slot;
    #1;
    {s, d, p, sz} = {src_val, dst_val, pc, op[1:0]};
    st = 32'h1 << sz;
    {mv, wr, ld, be, ae, ex, bo} = 7'h00;
    {ea, eb, wa} = {s, s + st, s};
    case (op[15:12])
      4'h6: begin
        ae = op[3:0] == 4'h3;
        {mv, ld} = {2{!ae}};
        be = op[3:2] == 2'h1 && op[11:8] != op[7:4];
        bo = !ae && (op[1:0] == 2'h3 || op[3]);
      end
      4'h2: begin
        {mv, wr, be} = {2'h3, op[2]};
        ea = op[2] ? d - st : d;
        eb = ea;
        bo = op[1:0] == 2'h3 || op[3];
      end
      4'h0: begin
        {mv, wr, ld} = {1'b1, !op[3], op[3]};
        ea = idx0_val + (op[3] ? s : d);
        bo = op[1:0] == 2'h3 || !op[2];
      end
      4'hE: begin
        ae = 1'b1;
        wa = {{24{op[7]}}, op[7:0]};
      end
      4'h9, 4'hD: begin
        {ex, mv, ld} = {slot, {2{!slot}}};
        sz = {op[14], !op[14]};
        ea = op[14] ? (p & 32'hFFFF_FFFC) + 32'h4 + {op[7:0], 2'h0} : p + 32'h4 + {op[7:0], 1'b0};
      end
      default: bo = 1'b1;
    endcase
    // An encoding outside this unit does nothing but raise the bad opcode pulse.
    if (bo) {mv, wr, ld, be, ae} = 5'h00;
    @(posedge clk);
    issue <= 1'b0;
    #1;
    check("flags", 32'({mem_req_q.valid, mem_req_q.write, wr_b_q.en, wr_a_q.en, pc_wr_q,
      slot_exc_q, bad_op_q}), 32'({mv, wr, be, ae, !ex && !bo, ex, bo}));
    if (mv) check("address", mem_req_q.addr, ea);
    if (mv) check("size", 32'(mem_req_q.size), 32'(sz));
    if (wr) check("store data", mem_req_q.wdata, s);
    if (be) check("update", wr_b_q.data, eb);
    if (ae) check("write", wr_a_q.data, wa);
    if (!ex) check("next address", pc_next_q, p + 32'h2);
    check("source mirror", 32'(src_sel_q), 32'(op[7:4]));
    if (ld) begin
      wa = mem_rdata;
      @(posedge clk);
      #1;
      wa = sz[1] ? wa : sz[0] ? {{16{wa[15]}}, wa[15:0]} : {{24{wa[7]}}, wa[7:0]};
      check("load target", 32'({wr_a_q.en, wr_a_q.idx}), 32'({1'b1, op[11:8]}));
      check("load data", wr_a_q.data, wa);
    end
  endtask
  // Every encoding four times with random fields, then the awkward cases.
  initial begin
    void'($urandom(19468));
    {sys_rst, issue, in_slot, instr} = {1'b1, 18'h0};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      foreach (ops[i]) begin
        r = $urandom;
        run(ops[i] | (ops[i][15] ? r[11:0] : {r[7:0], 4'h0}), 1'b0);
      end
      $display("random pass %0d done", k);
    end
    // A reset in mid-run must clear the request, both write enables, the strobe, the bad opcode pulse and the next address.
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("reset state", 32'({mem_req_q.valid, wr_a_q.en, wr_b_q.en, pc_wr_q, bad_op_q}), 32'h0);
    check("reset address", pc_next_q, 32'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    $display("mid-run reset done");
    // Encodings outside this unit, same register post-increment loads, and a delay slot flag on a non-relative load and on two PC-relative loads.
    run(16'h6007, 1'b0);
    run(16'h2008, 1'b0);
    run(16'h0008, 1'b0);
    run(16'h4A5B, 1'b0);
    run(16'h6556, 1'b0);
    run(16'h6774, 1'b1);
    run(16'h9A12, 1'b1);
    run(16'hD3FF, 1'b1);
    $display("same register and slot cases done");
    end_of_test();
  end
  // A hang well past the planned run length ends the test as a failure.
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
